// ===== rtl/pesl_pkg.sv
// Constants for the device error status and link capability register block.
// Assumes configuration accesses arrive as byte addresses within config space.
`default_nettype none
package pesl_pkg;
    localparam logic [11:0] PESL_DEVCTL_OFS = 12'h098;
    localparam logic [11:0] PESL_DEVSTS_OFS = 12'h09A;
    localparam logic [11:0] PESL_LNKCAP_OFS = 12'h09C;
    localparam logic [15:0] PESL_DEVCTL_RST = 16'h2800;
    localparam logic [15:0] PESL_DEVSTS_RST = 16'h0000;
    localparam int PESL_CTL_CORR   = 0;
    localparam int PESL_CTL_NONF   = 1;
    localparam int PESL_CTL_FATAL  = 2;
    localparam int PESL_CTL_UR     = 3;
    localparam int PESL_STS_CORR   = 0;
    localparam int PESL_STS_NONF   = 1;
    localparam int PESL_STS_FATAL  = 2;
    localparam int PESL_STS_UR     = 3;
    localparam int PESL_STS_AUX    = 4;
    localparam int PESL_STS_NONPOSTED_OUTSTANDING   = 5;
    localparam logic [15:0] PESL_CTL_WMASK = 16'hF8EF;
    localparam logic [7:0] PESL_PORT_NUM   = 8'h00;
    localparam logic [4:0] PESL_CAP_RSVD   = 5'h00;
    localparam logic       PESL_CLOCK_PM_CAPABLE     = 1'h1;
    localparam logic [2:0] PESL_L0S_COMMON = 3'h3;
    localparam logic [2:0] PESL_L0S_ASYNC  = 3'h4;
    localparam logic [1:0] PESL_ASPM_SUP   = 2'h3;
    localparam logic [5:0] PESL_MAX_LANES  = 6'h01;
    localparam logic [3:0] PESL_MAX_RATE   = 4'h1;
    typedef enum logic [1:0] {PESL_MSG_COR, PESL_MSG_NONFATAL, PESL_MSG_FATAL} pesl_msg_t;
endpackage
`default_nettype wire

// ===== rtl/pesl_sticky_flag.sv
// One write-one-to-clear sticky flag.
// Assumes event and clear are synchronous to the clock.
`default_nettype none
module pesl_sticky_flag
(
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_in,
    // Event and clear
    input  wire logic set_in,
    input  wire logic clr_in,
    // Flag
    output logic      flag_out
);
    logic flag_d;

    // A set in the clearing cycle wins, so no event is lost.
    assign flag_d = set_in | (flag_out & ~clr_in); // R20

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            flag_out <= 1'b0;
        else
            flag_out <= flag_d;
    end
endmodule
`default_nettype wire

// ===== rtl/pesl_msg_gen.sv
// Upstream error message request generator.
// Assumes the message sink accepts one request per cycle with msg_ack_in.
`default_nettype none
module pesl_msg_gen
    import pesl_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk_in,
    input  wire logic      rst_in,
    // Pending requests, one bit per message kind
    input  wire logic      fat_in,
    input  wire logic      nonf_in,
    input  wire logic      cor_in,
    // Message port
    input  wire logic      msg_ack_in,
    output logic           msg_valid_out,
    output pesl_msg_t      msg_type_out
);
    logic      fat_q, nonf_q, cor_q;
    logic      take;
    pesl_msg_t pick;

    // Fatal first, then nonfatal, then correctable.
    assign pick = fat_q ? PESL_MSG_FATAL : (nonf_q ? PESL_MSG_NONFATAL : PESL_MSG_COR);
    assign take = msg_valid_out & msg_ack_in;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fat_q         <= 1'b0;
            nonf_q        <= 1'b0;
            cor_q         <= 1'b0;
            msg_valid_out <= 1'b0;
            msg_type_out  <= PESL_MSG_COR;
        end
        else
        begin
            fat_q  <= fat_in | (fat_q & ~(take & msg_type_out == PESL_MSG_FATAL));
            nonf_q <= nonf_in | (nonf_q & ~(take & msg_type_out == PESL_MSG_NONFATAL));
            cor_q  <= cor_in | (cor_q & ~(take & msg_type_out == PESL_MSG_COR));
            if (!msg_valid_out || take)
            begin
                msg_valid_out <= (fat_q | nonf_q | cor_q) & ~take;
                msg_type_out  <= pick;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pesl_top.sv
// Device control error enables, device status and link capabilities registers.
// Assumes config reads and writes are single-cycle strobes on the core clock,
// and that error event inputs are one-cycle pulses.
`default_nettype none

// Functional notes
// R01 - Fatal enable bit 2 set: send fatal message on a fatal error event.
// R02 - Nonfatal enable bit 1 set: send nonfatal message on a nonfatal event.
// R03 - Correctable enable bit 0 set: send correctable message on such events.
// R04 - Unsupported request enable bit 3 set: send nonfatal message on such request.
// R05 - Device status bits 15:6 read zero.
// R06 - Status bit 5 shows a nonposted request still awaits completion.
// R07 - Status bit 4 shows auxiliary power present.
// R08 - Status bit 3 sets on unsupported request, stays until cleared.
// R09 - Status bit 2 sets on fatal error regardless of enable.
// R10 - Status bit 1 sets on nonfatal error regardless of enable.
// R11 - Status bit 0 sets on correctable error regardless of enable.
// R12 - Link capability bits 31:24 read port number zero.
// R13 - Link capability bits 23:19 read zero.
// R14 - Link capability bit 18 reads one, clock power management supported.
// R15 - L1 exit field picks diagnostic bits by the shared reference clock flag.
// R16 - L0s exit field reads 011b with shared clock, else 100b.
// R17 - ASPM support field reads 11b.
// R18 - Maximum lane count field reads 000001b.
// R19 - Maximum link speed field reads 1h.
// R20 - Writing one clears an error flag; a coinciding event keeps it set.
module pesl_top
    import pesl_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // Configuration access
    input  wire logic        cfg_rd_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [11:0] cfg_addr_in,
    input  wire logic [31:0] cfg_wdata_in,
    input  wire logic [3:0]  cfg_be_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // Device events and state
    input  wire logic        fatal_err_in,
    input  wire logic        nonfatal_err_in,
    input  wire logic        corr_err_in,
    input  wire logic        unsup_req_in,
    input  wire logic        nonposted_outstanding_in,
    input  wire logic        aux_power_present_in,
    // Link control and diagnostic inputs
    input  wire logic        shared_refclk_flag_in,
    input  wire logic [2:0]  diag_l1_exit_upper_in,
    input  wire logic [2:0]  diag_l1_exit_lower_in,
    // Upstream error messages
    input  wire logic        msg_ack_in,
    output logic             msg_valid_out,
    output pesl_msg_t        msg_type_out,
    // Control bits for the rest of the device
    output logic [15:0]      devctl_out
);
    logic [15:0] devctl_q, devctl_d;
    logic        nonposted_outstanding_q, aux_q;
    logic [3:0]  err_flags;
    logic [3:0]  err_set;
    logic [3:0]  err_clr;
    logic [15:0] devsts;
    logic [31:0] lnkcap;
    logic [31:0] rdata_d;
    logic        hit_ctl_sts, hit_cap;
    logic [15:0] sts_wr;

    // Word containing control and status sits at the control offset.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    assign hit_ctl_sts = hit(cfg_addr_in, PESL_DEVCTL_OFS);
    assign hit_cap     = hit(cfg_addr_in, PESL_LNKCAP_OFS);
    assign sts_wr      = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}}} & cfg_wdata_in[31:16];

    // Only writable control bits change; the rest hold their reset value.
    assign devctl_d = (devctl_q & ~(PESL_CTL_WMASK & {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}}))
                    | (cfg_wdata_in[15:0] & PESL_CTL_WMASK
                       & {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}});

    assign err_set[PESL_STS_CORR]  = corr_err_in;     // R11
    assign err_set[PESL_STS_NONF]  = nonfatal_err_in; // R10
    assign err_set[PESL_STS_FATAL] = fatal_err_in;    // R09
    assign err_set[PESL_STS_UR]    = unsup_req_in;    // R08
    assign err_clr = (cfg_wr_in && hit_ctl_sts) ? sts_wr[3:0] : 4'h0; // R20

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_flag
            pesl_sticky_flag u_flag
            (
                .mclk_in  (mclk_in),
                .rst_in   (rst_in),
                .set_in   (err_set[gi]),
                .clr_in   (err_clr[gi]),
                .flag_out (err_flags[gi])
            );
        end
    endgenerate

    assign devsts = {10'h000, nonposted_outstanding_q, aux_q, err_flags}; // R05 R06 R07

    assign lnkcap = {PESL_PORT_NUM,                                  // R12
                     PESL_CAP_RSVD,                                  // R13
                     PESL_CLOCK_PM_CAPABLE,                                    // R14
                     shared_refclk_flag_in ? diag_l1_exit_upper_in
                                           : diag_l1_exit_lower_in,  // R15
                     shared_refclk_flag_in ? PESL_L0S_COMMON
                                           : PESL_L0S_ASYNC,         // R16
                     PESL_ASPM_SUP,                                  // R17
                     PESL_MAX_LANES,                                 // R18
                     PESL_MAX_RATE};                                 // R19

    // Unmapped addresses read as zero.
    assign rdata_d = hit_ctl_sts ? {devsts, devctl_q} : (hit_cap ? lnkcap : 32'h0000_0000);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            devctl_q       <= PESL_DEVCTL_RST;
            nonposted_outstanding_q         <= 1'b0;
            aux_q          <= 1'b0;
            cfg_rdata_out  <= 32'h0000_0000;
            cfg_rvalid_out <= 1'b0;
            devctl_out     <= PESL_DEVCTL_RST;
        end
        else
        begin
            if (cfg_wr_in && hit_ctl_sts)
                devctl_q <= devctl_d;
            nonposted_outstanding_q         <= nonposted_outstanding_in; // R06
            aux_q          <= aux_power_present_in;     // R07
            cfg_rvalid_out <= cfg_rd_in;
            cfg_rdata_out  <= cfg_rd_in ? rdata_d : 32'h0000_0000;
            devctl_out     <= (cfg_wr_in && hit_ctl_sts) ? devctl_d : devctl_q;
        end
    end

    pesl_msg_gen u_msg
    (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .fat_in        (fatal_err_in & devctl_q[PESL_CTL_FATAL]),                 // R01
        .nonf_in       ((nonfatal_err_in & devctl_q[PESL_CTL_NONF])               // R02
                        | (unsup_req_in & devctl_q[PESL_CTL_UR])),                // R04
        .cor_in        (corr_err_in & devctl_q[PESL_CTL_CORR]),                   // R03
        .msg_ack_in    (msg_ack_in),
        .msg_valid_out (msg_valid_out),
        .msg_type_out  (msg_type_out)
    );
endmodule
`default_nettype wire

// ===== test/pesl_msg_sink.sv
// Upstream message sink standing in for the root complex.
// Assumes one message per handshake; dly_in sets how many cycles it stalls.
`default_nettype none
module pesl_msg_sink
    import pesl_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // Message port
    input  wire logic       msg_valid_in,
    input  wire pesl_msg_t  msg_type_in,
    input  wire logic [1:0] dly_in,
    output var  logic       msg_ack_out
);
    int         got [3];
    logic [1:0] wait_q;
    always @(posedge mclk_in or posedge rst_in)
        if (rst_in)
        begin
            msg_ack_out <= 1'b0;
            wait_q <= 2'h0;
            got <= '{0, 0, 0};
        end
        else if (msg_valid_in && msg_ack_out)
        begin
            msg_ack_out <= 1'b0;
            wait_q <= 2'h0;
            got[msg_type_in] <= got[msg_type_in] + 1;
        end
        else if (msg_valid_in && wait_q >= dly_in)
            msg_ack_out <= 1'b1;
        else if (msg_valid_in)
            wait_q <= wait_q + 2'h1;
endmodule
`default_nettype wire

// ===== test/pesl_top_assertions.sv
// Port-level checker for the error status and link capability block.
// Assumes it is bound to pesl_top and sees only that module's ports.
`default_nettype none
module pesl_top_assertions
    import pesl_pkg::*;
(
    // Clock, reset and configuration access
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic        cfg_rd_in,
    input wire logic        cfg_wr_in,
    input wire logic [11:0] cfg_addr_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [3:0]  cfg_be_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic        cfg_rvalid_out,
    // Events, link state and messages
    input wire logic        fatal_err_in,
    input wire logic        nonfatal_err_in,
    input wire logic        corr_err_in,
    input wire logic        unsup_req_in,
    input wire logic        shared_refclk_flag_in,
    input wire logic [2:0]  diag_l1_exit_upper_in,
    input wire logic [2:0]  diag_l1_exit_lower_in,
    input wire logic        msg_ack_in,
    input wire logic        msg_valid_out,
    input wire pesl_msg_t   msg_type_out,
    input wire logic [15:0] devctl_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire        rd_ctl = cfg_rd_in && cfg_addr_in[11:2] == 10'h026;
    wire        rd_cap = cfg_rd_in && cfg_addr_in[11:2] == 10'h027;
    wire        wr_ctl = cfg_wr_in && cfg_addr_in[11:2] == 10'h026 && cfg_be_in[1:0] == 2'h3;
    wire [15:0] wr_lo = cfg_wdata_in[15:0];
    read_answer_a: assert property (cfg_rd_in |=> cfg_rvalid_out)
        else $error("read got no answer");
    fixed_caps_a: assert property (rd_cap |=> cfg_rdata_out[31:18] == 14'h0001 &&
        cfg_rdata_out[11:0] == 12'hC11)
        else $error("fixed capability fields wrong");
    l0s_exit_a: assert property (rd_cap |=> cfg_rdata_out[14:12] ==
        ($past(shared_refclk_flag_in) ? 3'h3 : 3'h4)) else $error("L0s exit field wrong");
    l1_exit_a: assert property (rd_cap |=> cfg_rdata_out[17:15] ==
        ($past(shared_refclk_flag_in) ? $past(diag_l1_exit_upper_in)
                                      : $past(diag_l1_exit_lower_in)))
        else $error("L1 field wrong");
    status_rsvd_a: assert property (rd_ctl |=> cfg_rdata_out[31:22] == 10'h000)
        else $error("reserved status bits set");
    ctl_write_a: assert property (wr_ctl |=>
        devctl_out == ($past(wr_lo) & 16'hF8EF)) else $error("device control write wrong");
    fatal_msg_a: assert property (fatal_err_in && devctl_out[2] |->
        ##[1:8] msg_valid_out && msg_type_out == PESL_MSG_FATAL) else $error("no fatal message");
    nonfatal_msg_a: assert property ((nonfatal_err_in && devctl_out[1]) ||
        (unsup_req_in && devctl_out[3]) |-> ##[1:12] msg_valid_out &&
        msg_type_out == PESL_MSG_NONFATAL) else $error("no nonfatal message");
    cor_msg_a: assert property (corr_err_in && devctl_out[0] |->
        ##[1:16] msg_valid_out && msg_type_out == PESL_MSG_COR)
        else $error("no correctable message");
    msg_hold_a: assert property (msg_valid_out && !msg_ack_in |=>
        msg_valid_out && $stable(msg_type_out)) else $error("message dropped before ack");
    cover property (msg_valid_out && msg_ack_in);
    cover property (rd_cap ##1 cfg_rvalid_out);
    cover property (fatal_err_in && devctl_out[2]);
endmodule
bind pesl_top pesl_top_assertions chk (.*);
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for pesl_top with a root complex message sink.
// Assumes a 25 MHz core clock and inputs driven on the falling edge.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                mclk_in, rst_in, cfg_rd_in, cfg_wr_in, shared_refclk_flag_in;
    logic                nonposted_outstanding_in, aux_power_present_in, msg_ack_in;
    logic                msg_valid_out, cfg_rvalid_out;
    logic [11:0]         cfg_addr_in;
    logic [31:0]         cfg_wdata_in, cfg_rdata_out;
    logic [3:0]          cfg_be_in, ev;
    logic [2:0]          diag_l1_exit_upper_in, diag_l1_exit_lower_in;
    logic [1:0]          dly;
    logic [15:0]         devctl_out;
    pesl_pkg::pesl_msg_t msg_type_out;
    int                  error_cnt, total_checks, i, k;
    int                  want [3];
    pesl_top DUT (.*, .corr_err_in(ev[0]), .nonfatal_err_in(ev[1]), .fatal_err_in(ev[2]),
        .unsup_req_in(ev[3]));
    pesl_msg_sink sink (.mclk_in, .rst_in, .msg_valid_in(msg_valid_out),
        .msg_type_in(msg_type_out), .dly_in(dly), .msg_ack_out(msg_ack_in));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
        input logic [3:0] e);
        @(negedge mclk_in);
        {cfg_wr_in, cfg_addr_in, cfg_wdata_in, cfg_be_in, ev} = {1'b1, a, d, b, e};
        @(negedge mclk_in);
        {cfg_wr_in, ev} = 5'h00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(negedge mclk_in);
        {cfg_rd_in, cfg_addr_in} = {1'b1, a};
        @(negedge mclk_in);
        cfg_rd_in = 1'b0;
        chk(nm, cfg_rdata_out, exp);
    endtask
    task automatic pulse(input logic [3:0] e);
        wr(12'h0A4, 32'h0, 4'h0, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        {rst_in, cfg_rd_in, cfg_wr_in, ev} = 7'h40;
        {nonposted_outstanding_in, aux_power_present_in} = 2'h0;
        {shared_refclk_flag_in, cfg_addr_in, cfg_wdata_in, cfg_be_in, dly} = '0;
        diag_l1_exit_upper_in = 3'h2;
        diag_l1_exit_lower_in = 3'h5;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 1'b0;
        rd(12'h098, 32'h0000_2800, "ctl word");
        rd(12'h0A4, 32'h0, "unmapped");
        wr(12'h09C, 32'hFFFF_FFFF, 4'hF, 4'h0);
        for (i = 0; i < 2; i++)
        begin
            shared_refclk_flag_in = i[0];
            rd(12'h09C, {14'h0001, i[0] ? 6'h13 : 6'h2C, 12'hC11},
                "caps");
        end
        $display("test capabilities done");
        wr(12'h098, 32'hFFFF_FFFF, 4'h3, 4'h0);
        chk("devctl", {16'h0, devctl_out}, 32'h0000_F8EF);
        wr(12'h098, 32'h0000_2800, 4'h3, 4'h0);
        {nonposted_outstanding_in, aux_power_present_in} = 2'h3;
        for (i = 0; i < 4; i++)
            pulse(4'h1 << i);
        rd(12'h098, 32'h003F_2800, "flags set");
        chk("silent", sink.got[0] + sink.got[1] + sink.got[2], 32'h0);
        wr(12'h098, 32'h000A_0000, 4'hC, 4'h0);
        rd(12'h098, 32'h0035_2800, "partial clear");
        wr(12'h098, 32'h0001_0000, 4'hC, 4'h1);
        rd(12'h098, 32'h0035_2800, "set beats clear");
        nonposted_outstanding_in = 1'b0;
        wr(12'h098, 32'hFFFF_0000, 4'hC, 4'h0);
        rd(12'h098, 32'h0010_2800, "all clear");
        $display("test status flags done");
        wr(12'h098, 32'h0000_280F, 4'h3, 4'h0);
        for (i = 0; i < 9; i++)
        begin
            dly = i[2] ? 2'h3 : 2'h0;
            k = i[1:0] == 2'h3 ? 1 : i[1:0];
            pulse(i == 8 ? 4'h7 : 4'h1 << i[1:0]);
            want[k]++;
            // The combined pulse also raises nonfatal and fatal, one message of each.
            if (i == 8)
                {want[1], want[2]} = {want[1] + 1, want[2] + 1};
            repeat (20) @(negedge mclk_in);
            chk("msg counts", {sink.got[0][7:0], sink.got[1][7:0], sink.got[2][7:0]},
                {want[0][7:0], want[1][7:0], want[2][7:0]});
        end
        $display("test messages done");
        end_of_test();
    end
endmodule
`default_nettype wire
